/* File: core/mfa_consts.svh */
/*
 Constants of the motor fault acknowledgement core: register offsets, field positions,
 reset values and timing counts. Holds definitions only; included by bare name.
*/
`ifndef MFA_CONSTS_SVH
`define MFA_CONSTS_SVH

// Fault kinds and their positions in every per-kind vector.
`define MFA_NFAULT 8
`define MFA_K_OVL 0
`define MFA_K_OVA 1
`define MFA_K_THM 2
`define MFA_K_BUS 3
`define MFA_OVL_MASK 8'h03
`define MFA_AUTO_MASK 8'h07
`define MFA_FORCE_STORE 8'h07

// Register byte offsets, one aligned word each.
`define MFA_A_CTRL 8'h00
`define MFA_A_CLASS 8'h04
`define MFA_A_ACKMODE 8'h08
`define MFA_A_STATUS 8'h0C
`define MFA_A_ISTAT 8'h10
`define MFA_A_IMASK 8'h14
`define MFA_A_ROUTE 8'h18
`define MFA_A_COOL 8'h1C
`define MFA_A_CMD 8'h20

// Reset values.
`define MFA_RST_CLASS 16'h0000
`define MFA_RST_ACKMODE 8'hFF
`define MFA_RST_ROUTE 8'h00
`define MFA_RST_COOL 16'h03E8

// Cooling time is counted in 1 ms ticks of the 20 ns clock.
`define MFA_CLK_NS 20
`define MFA_TICK_NS 1000000
`define MFA_TICK_CYC ((`MFA_TICK_NS + `MFA_CLK_NS - 1) / `MFA_CLK_NS)

`endif

/* File: core/mfa_cool_timer.sv */
/*
 Cooling time counter: a millisecond divider and a down counter.
 Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mfa_cool_timer #(
   parameter int TICK_CYCLES = 50000,
   parameter int TW = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [TW-1:0] load,
   output logic busy
);
   import mfa_pkg::*;
   localparam int DW = $clog2(TICK_CYCLES + 1);
   typedef struct packed {
      logic [DW-1:0] div;
      logic [TW-1:0] left;
      logic busy;
   } mfa_tmr_t;
   mfa_tmr_t s;
   mfa_tmr_t n;

   // The divider only runs while cooling, so an idle timer costs no toggling.
   always_comb begin
      n = s;
      if (start) begin
         n.div = '0;
         n.left = load;
         n.busy = (load != '0);
      end else if (s.busy) begin
         if (s.div == DW'(TICK_CYCLES - 1)) begin
            n.div = '0;
            n.left = s.left - 1'b1;
            n.busy = (s.left != {{(TW-1){1'b0}}, 1'b1});
         end else begin
            n.div = s.div + 1'b1;
         end
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign busy = s.busy;

   AST_COOL_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
      (start && load != '0) |=> busy [*2]) else $error("cooling time did not start");
endmodule
`default_nettype wire

/* File: core/mfa_fault_ack.sv */
/*
 Fault reaction and acknowledgement core of a motor protection unit, with an AHB-Lite
 register slave. Assumes one 50 MHz clock, single word transfers, asynchronous pins
 for faults and buttons, and run commands from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mfa_consts.svh"

// Contract
// - Any fault lights the general fault indicator on the main unit and the operator panel; the code leaves it dark for warning-class faults.
// - A fieldbus fault also switches off the bus status indicator.
// - Each detected fault sets its own bit in the data reported to the fieldbus master.
// - A fault drops all contactor control outputs; the code does so only for shutdown and off-class faults.
// - A fault turns the fault lamp control output on; the code leaves it off for warning-class faults.
// - A fault sets a general fault flag apart from the per-kind fault bits; the code does not set it for warning-class faults.
// - The general fault flag and the lamp signal can be routed to any output relay.
// - For immediate kinds a reset clears the fault and re-enables the contactors at once.
// - For stored kinds a reset during the fault is kept and releases the fault when its cause is gone.
// - After an overload trip a stored reset waits for the cooling time before releasing.
// - The test/reset button of the main unit or of the panel acknowledges faults.
// - Any of three auxiliary reset inputs, by pushbutton or fieldbus bit, acknowledges faults.
// - The enabled automatic reset acknowledges only overload, overload with asymmetry and thermistor trips.
// - An opposing control command such as motor off acknowledges a pending fault.
// - The contactor reaction follows the class of each fault: shutdown, warning, off or retain.
module mfa_fault_ack #(
   parameter int TICK_CYCLES = `MFA_TICK_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] fault_in,
   input wire logic test_reset_btn_main,
   input wire logic test_reset_btn_panel,
   input wire logic aux_ack_in_a,
   input wire logic aux_ack_in_b,
   input wire logic aux_ack_in_c,
   input wire logic motor_off_cmd,
   input wire logic [2:0] run_cmd,
   output logic contactor_ctrl_a,
   output logic contactor_ctrl_b,
   output logic contactor_ctrl_c,
   output logic fault_lamp_ctrl,
   output logic gen_fault_flag,
   output logic gen_fault_led_main,
   output logic gen_fault_led_panel,
   output logic bus_led,
   output logic [7:0] fault_bits,
   output logic [3:0] relay_out,
   output logic irq
);
   import mfa_pkg::*;

   typedef struct packed {
      mfa_bus_t ph;
      logic pwr;
      logic [7:0] pad;
      logic hrdy;
      logic resp;
      logic [31:0] rdat;
      logic cmd_ack;
      logic auto_en;
      logic [15:0] cls;
      logic [7:0] amode;
      logic [7:0] istat;
      logic [7:0] imask;
      logic [7:0] route;
      logic [15:0] cool;
      logic [7:0] lat;
      logic [7:0] sto;
      logic [7:0] fprev;
      logic [5:0] bprev;
      logic [2:0] con;
      logic lamp;
      logic led;
      logic bus_led;
      logic [7:0] fbits;
      logic [3:0] relay;
      logic irq;
   } mfa_state_t;

   mfa_state_t s;
   mfa_state_t n;
   logic [13:0] syn;
   logic [7:0] fnow;
   logic [7:0] shutm;
   logic [7:0] warnm;
   logic [7:0] offm;
   logic [7:0] keepm;
   logic [7:0] latchable;
   logic cool_start;
   logic cool_busy;

   // Returns the kinds whose two-bit class field equals the given class.
   function automatic logic [7:0] mask_of(input logic [15:0] c, input mfa_class_t k);
      logic [7:0] m;
      m = '0;
      for (int i = 0; i < `MFA_NFAULT; i++) begin
         m[i] = (c[2*i +: 2] == k);
      end
      return m;
   endfunction

   // Faults, buttons and the motor-off command all arrive on pins, so all pass the filter.
   mfa_sync #(
      .W(14)
   ) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .d({motor_off_cmd, aux_ack_in_c, aux_ack_in_b, aux_ack_in_a,
          test_reset_btn_panel, test_reset_btn_main, fault_in}),
      .q(syn)
   );

   // Class decode; warning and off kinds never latch, so they need no acknowledgement.
   assign fnow = syn[7:0];
   assign shutm = mask_of(s.cls, MFA_CL_SHUT);
   assign warnm = mask_of(s.cls, MFA_CL_WARN);
   assign offm = mask_of(s.cls, MFA_CL_OFF);
   assign keepm = mask_of(s.cls, MFA_CL_KEEP);
   assign latchable = shutm | keepm;

   // A new overload trip restarts the cooling time.
   assign cool_start = |(fnow & `MFA_OVL_MASK & latchable & ~s.lat);

   mfa_cool_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .TW(16)
   ) u_cool (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(cool_start),
      .load(s.cool),
      .busy(cool_busy)
   );

   // Next-state logic: bus slave first, then fault handling, indicators and interrupt.
   always_comb begin
      logic ack;
      logic anyf;
      logic [5:0] bnow;
      logic [7:0] rel;
      logic [7:0] smode;
      logic [7:0] aack;
      logic [7:0] st;
      logic [7:0] clr;
      logic [7:0] evt;
      logic [7:0] w1c;
      n = s;
      ack = 1'b0;
      anyf = 1'b0;
      bnow = syn[13:8];
      rel = '0;
      smode = '0;
      aack = '0;
      st = '0;
      clr = '0;
      evt = '0;
      w1c = '0;
      n.cmd_ack = 1'b0;
      n.resp = 1'b0;

      // One wait state per transfer keeps read data registered and always current.
      case (s.ph)
         MFA_BUS_DATA: begin
            n.ph = MFA_BUS_IDLE;
            n.hrdy = 1'b1;
            if (s.pwr) begin
               case (s.pad)
                  `MFA_A_CTRL: n.auto_en = hwdata[0];
                  `MFA_A_CLASS: n.cls = hwdata[15:0];
                  `MFA_A_ACKMODE: n.amode = hwdata[7:0];
                  `MFA_A_ISTAT: w1c = hwdata[7:0];
                  `MFA_A_IMASK: n.imask = hwdata[7:0];
                  `MFA_A_ROUTE: n.route = hwdata[7:0];
                  `MFA_A_COOL: n.cool = hwdata[15:0];
                  `MFA_A_CMD: n.cmd_ack = |hwdata[2:0];
                  default: n.cmd_ack = 1'b0;
               endcase
            end else begin
               case (s.pad)
                  `MFA_A_CTRL: n.rdat = {31'h0, s.auto_en};
                  `MFA_A_CLASS: n.rdat = {16'h0, s.cls};
                  `MFA_A_ACKMODE: n.rdat = {24'h0, s.amode};
                  `MFA_A_STATUS: n.rdat = {13'h0, cool_busy, |(fnow & warnm), s.led, s.sto, s.lat};
                  `MFA_A_ISTAT: n.rdat = {24'h0, s.istat};
                  `MFA_A_IMASK: n.rdat = {24'h0, s.imask};
                  `MFA_A_ROUTE: n.rdat = {24'h0, s.route};
                  `MFA_A_COOL: n.rdat = {16'h0, s.cool};
                  default: n.rdat = 32'h0;
               endcase
            end
         end
         default: begin
            n.ph = MFA_BUS_IDLE;
            n.hrdy = 1'b1;
         end
      endcase
      if (hsel && hready && htrans[1]) begin
         n.ph = MFA_BUS_DATA;
         n.hrdy = 1'b0;
         n.pad = haddr[7:0];
         n.pwr = hwrite;
      end

      // Any rising button, auxiliary input or motor-off edge, or a bus command, is one acknowledge.
      ack = (|(bnow & ~s.bprev)) | s.cmd_ack;
      n.bprev = bnow;

      // Release: cause gone, and for overload kinds the cooling time over as well.
      rel = ~fnow & ~(`MFA_OVL_MASK & {8{cool_busy}});
      smode = s.amode | `MFA_FORCE_STORE;
      aack = `MFA_AUTO_MASK & {8{s.auto_en}};
      st = s.sto | (smode & s.lat & ({8{ack}} | aack));
      clr = (~smode & s.lat & {8{ack}}) | (st & rel);

      // A cause still present sets the latch again, so it wins over any clear.
      n.lat = (fnow & latchable) | (s.lat & ~clr);
      n.sto = st & ~rel & n.lat;

      // Indicators follow the latched faults and the active off-class faults.
      anyf = (|n.lat) | (|(fnow & offm));
      n.led = anyf;
      n.lamp = anyf;
      n.fbits = n.lat | fnow;
      n.bus_led = ~(fnow[`MFA_K_BUS] | n.lat[`MFA_K_BUS]);

      // Shutdown beats retain; retain freezes the contactors at their last state.
      if ((|(n.lat & shutm)) || (|(fnow & offm))) begin
         n.con = 3'h0;
      end else if (|(n.lat & keepm)) begin
         n.con = s.con;
      end else begin
         n.con = run_cmd;
      end

      // Each relay selects off, general fault flag, lamp signal or steady on.
      for (int r = 0; r < 4; r++) begin
         case (s.route[2*r +: 2])
            2'h1: n.relay[r] = anyf;
            2'h2: n.relay[r] = anyf;
            2'h3: n.relay[r] = 1'b1;
            default: n.relay[r] = 1'b0;
         endcase
      end

      // New fault causes set sticky bits; a new event wins over a write-one clear.
      evt = fnow & ~s.fprev;
      n.fprev = fnow;
      n.istat = (s.istat & ~w1c) | evt;
      n.irq = |(n.istat & s.imask);
   end

   // State register; the bus indicator and bus-ready idle high after reset.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= '0;
         s.hrdy <= 1'b1;
         s.bus_led <= 1'b1;
         s.cls <= `MFA_RST_CLASS;
         s.amode <= `MFA_RST_ACKMODE;
         s.route <= `MFA_RST_ROUTE;
         s.cool <= `MFA_RST_COOL;
      end else begin
         s <= n;
      end
   end

   // Outputs come straight from the state register.
   assign hrdata = s.rdat;
   assign hreadyout = s.hrdy;
   assign hresp = s.resp;
   assign contactor_ctrl_a = s.con[0];
   assign contactor_ctrl_b = s.con[1];
   assign contactor_ctrl_c = s.con[2];
   assign fault_lamp_ctrl = s.lamp;
   assign gen_fault_flag = s.led;
   assign gen_fault_led_main = s.led;
   assign gen_fault_led_panel = s.led;
   assign bus_led = s.bus_led;
   assign fault_bits = s.fbits;
   assign relay_out = s.relay;
   assign irq = s.irq;

   // Check helpers: kinds that an acknowledge or a release must clear at the next edge.
   logic ack_seen;
   logic [7:0] imm_due;
   logic [7:0] sto_due;
   assign ack_seen = (|(syn[13:8] & ~s.bprev)) | s.cmd_ack;
   assign imm_due = s.lat & ~(s.amode | `MFA_FORCE_STORE) & ~fnow & {8{ack_seen}};
   assign sto_due = s.sto & ~fnow & ~`MFA_OVL_MASK;

   AST_LED_BOTH: assert property (@(posedge mclk) disable iff (!rst_n)
      (|s.lat) |-> (gen_fault_led_main && gen_fault_led_panel)) else $error("fault indicator dark while latched");

   AST_BUS_LED: assert property (@(posedge mclk) disable iff (!rst_n)
      fnow[`MFA_K_BUS] |=> !bus_led) else $error("bus indicator lit during bus fault");

   AST_FAULT_BITS: assert property (@(posedge mclk) disable iff (!rst_n)
      (fnow != 8'h00) |=> ((fault_bits & $past(fnow)) == $past(fnow))) else $error("fault bit missing");

   AST_CON_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      (|(s.lat & shutm)) |-> (s.con == 3'h0)) else $error("contactor on during shutdown fault");

   AST_LAMP: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(|s.lat) |-> fault_lamp_ctrl) else $error("lamp off on new fault");

   AST_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
      (|(fnow & latchable)) |=> gen_fault_flag) else $error("general flag not set");

   AST_COOL_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (s.lat[`MFA_K_OVL] && cool_busy) |=> s.lat[`MFA_K_OVL]) else $error("overload released during cooling");

   AST_THM_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (s.lat[`MFA_K_THM] && fnow[`MFA_K_THM]) |=> s.lat[`MFA_K_THM]) else $error("thermistor released while hot");

   AST_AUTO_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
      (s.auto_en && !ack_seen && ((s.sto & ~`MFA_AUTO_MASK) == 8'h00))
      |=> ((s.lat & $past(s.lat) & ~`MFA_AUTO_MASK) == ($past(s.lat) & ~`MFA_AUTO_MASK)))
      else $error("automatic reset cleared a foreign kind");

   AST_BUS_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
      (hsel && hready && htrans[1]) |=> !hreadyout ##1 hreadyout) else $error("bus wait state wrong");

   AST_IMM_ACK: assert property (@(posedge mclk) disable iff (!rst_n)
      (imm_due != 8'h00) |=> ((s.lat & $past(imm_due)) == 8'h00)) else $error("immediate kind kept after reset");

   AST_STORE_REL: assert property (@(posedge mclk) disable iff (!rst_n)
      (sto_due != 8'h00) |=> ((s.lat & $past(sto_due)) == 8'h00)) else $error("stored reset not released");

   AST_OFF_CON: assert property (@(posedge mclk) disable iff (!rst_n)
      (|(fnow & offm)) |=> (s.con == 3'h0)) else $error("contactor on during off-class fault");

   AST_RELAY_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
      (s.route[3:2] == 2'h1) |=> (relay_out[1] == gen_fault_flag)) else $error("relay does not follow flag");

   AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
      (s.imask == $past(s.imask)) |-> (irq == (|(s.istat & s.imask)))) else $error("interrupt level wrong");

   AST_RESP_OKAY: assert property (@(posedge mclk) disable iff (!rst_n)
      !hresp) else $error("error response on the bus");
endmodule
`default_nettype wire

/* File: core/mfa_pkg.sv */
/*
 Types shared by the motor fault acknowledgement core.
 Assumes nothing of its surroundings.
*/
package mfa_pkg;
   typedef enum logic [1:0] {
      MFA_CL_SHUT = 2'b00,
      MFA_CL_WARN = 2'b01,
      MFA_CL_OFF = 2'b10,
      MFA_CL_KEEP = 2'b11
   } mfa_class_t;
   typedef enum logic [0:0] {
      MFA_BUS_IDLE = 1'b0,
      MFA_BUS_DATA = 1'b1
   } mfa_bus_t;
endpackage

/* File: core/mfa_sync.sv */
/*
 Three-stage input synchroniser with agreement filter for asynchronous pins.
 Assumes the inputs are levels that stay for several clock periods.
*/
`timescale 1ns/100ps
`default_nettype none
module mfa_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import mfa_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } mfa_sync_t;
   mfa_sync_t s;
   mfa_sync_t n;

   // A bit only changes once the second and third stages agree, so one stray sample cannot pass.
   always_comb begin
      n = s;
      n.s1 = d;
      n.s2 = s.s1;
      n.s3 = s.s2;
      n.q = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
   end

   // State register with synchronous reset.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign q = s.q;

   AST_SYNC_AGREE: assert property (@(posedge mclk) disable iff (!rst_n)
      (s.q != $past(s.q)) |-> ($past(s.s2) == $past(s.s3))) else $error("sync output moved without agreement");
endmodule
`default_nettype wire

/* File: dv/mfa_fault_ack_test.sv */
/*
 Self-checking bench of the fault reaction core: AHB-Lite master, fault pins and operator model.
 Assumes the core answers each transfer through hreadyout and filters pins within five edges.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mfa_consts.svh"
module mfa_fault_ack_test;
   logic mclk, rst_n, hsel, hwrite, hreadyout, go, irq;
   logic [31:0] haddr, hwdata, hrdata, seed, route;
   logic [1:0] htrans;
   logic [7:0] fault_in, fb;
   logic [2:0] run_cmd, rc, sel, con;
   logic [3:0] hold, rly;
   logic [5:0] btn;
   logic lamp, flag, lm, lp, busl, hresp;
   int fail_count, n_compared, k;
   wire [19:0] obs = {con, lamp, flag, lm, lp, busl, fb, rly};
   logic [7:0] ra [6] = '{8'h04, 8'h08, 8'h18, 8'h1C, 8'h0C, 8'h3C};
   logic [31:0] rv [6] = '{32'h0, 32'hFF, 32'h0, 32'h3E8, 32'h0, 32'h0};

   mfa_fault_ack #(.TICK_CYCLES(5)) mfa_fault_ack_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in),
      .test_reset_btn_main(btn[0]), .test_reset_btn_panel(btn[1]), .aux_ack_in_a(btn[2]),
      .aux_ack_in_b(btn[3]), .aux_ack_in_c(btn[4]), .motor_off_cmd(btn[5]), .run_cmd(run_cmd),
      .contactor_ctrl_a(con[0]), .contactor_ctrl_b(con[1]), .contactor_ctrl_c(con[2]),
      .fault_lamp_ctrl(lamp), .gen_fault_flag(flag), .gen_fault_led_main(lm),
      .gen_fault_led_panel(lp), .bus_led(busl), .fault_bits(fb), .relay_out(rly), .irq(irq));
   mfa_op_model mfa_op_model_inst (.mclk(mclk), .go(go), .sel(sel), .hold(hold), .btn(btn));

   // Free-running 50 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected outputs; relay selection 1 and 2 both follow the fault indication.
   function automatic logic [19:0] expo(input logic [2:0] c, input logic f, input logic b,
                                        input logic [7:0] e);
      logic [3:0] r;
      for (int i = 0; i < 4; i++) r[i] = route[2*i+1] ? (route[2*i] | f) : (route[2*i] & f);
      return {c, {4{f}}, b, e, r};
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   // Outputs are looked at mid-period, where the edge's updates have landed.
   task automatic chk_out(input string n, input logic [19:0] e);
      @(negedge mclk);
      chk(n, {12'h0, e}, {12'h0, obs});
      @(posedge mclk);
   endtask

   task automatic chk_irq(input logic e);
      @(negedge mclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
      @(posedge mclk);
   endtask

   // One single AHB transfer; entered and left just after a rising edge.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge mclk); while (!hreadyout && ++n < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (!hreadyout && ++n < 40);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask

   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(n, e, q);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   // Source 6 is a fieldbus reset bit written to the command register.
   task automatic ack(input int s);
      if (s == 6) begin
         wr(`MFA_A_CMD, {29'h0, 3'h1 << (rnd() % 3)});
      end else begin
         go <= 1'b1;
         sel <= 3'(s);
         hold <= 4'(6 + rnd() % 8);
         @(posedge mclk);
         go <= 1'b0;
      end
      repeat (24) @(posedge mclk);
   endtask

   task automatic pin(input int i, input logic v);
      fault_in[i] <= v;
      repeat (8) @(posedge mclk);
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // A hang counts as a mismatch and ends the run the normal way.
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      summarize();
   end

   // Main sequence.
   initial begin
      seed = 32'h11;
      {rst_n, hsel, hwrite, go, htrans, haddr, hwdata, fault_in, sel, hold, route} = '0;
      fail_count = 0;
      n_compared = 0;
      rc = 3'(rnd()) | 3'h4;
      run_cmd = rc;
      repeat (11) @(posedge mclk);
      chk_out("reset", expo(3'h0, 1'b0, 1'b1, 8'h0));
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 6; i++) rdc("regs", ra[i], rv[i]);
      route = 32'hE4;
      wr(`MFA_A_ROUTE, route);
      wr(`MFA_A_IMASK, 32'hFF);
      $display("test reset done");
      for (int m = 0; m < 2; m++) begin
         wr(`MFA_A_ACKMODE, m ? 32'h0 : 32'hFF);
         for (int s = 0; s < 7; s++) begin
            k = 4 + rnd() % 4;
            pin(k, 1'b1);
            chk_out("trip", expo(3'h0, 1'b1, 1'b1, 8'h1 << k));
            rdc("istat", `MFA_A_ISTAT, 32'h1 << k);
            chk_irq(1'b1);
            if (m) pin(k, 1'b0);
            else ack(s);
            chk_out("held", expo(3'h0, 1'b1, 1'b1, 8'h1 << k));
            if (!m) rdc("status", `MFA_A_STATUS, 32'h10000 | 32'h101 << k);
            if (m) ack(s);
            else pin(k, 1'b0);
            chk_out("freed", expo(rc, 1'b0, 1'b1, 8'h0));
            wr(`MFA_A_ISTAT, 32'hFF);
            chk_irq(1'b0);
         end
      end
      $display("test ack sources done");
      pin(3, 1'b1);
      chk_out("bus", expo(3'h0, 1'b1, 1'b0, 8'h08));
      pin(3, 1'b0);
      ack(0);
      chk_out("bus ok", expo(rc, 1'b0, 1'b1, 8'h0));
      wr(`MFA_A_COOL, 32'h14);
      pin(0, 1'b1);
      chk_out("ovl", expo(3'h0, 1'b1, 1'b1, 8'h01));
      pin(0, 1'b0);
      ack(1);
      chk_out("cooling", expo(3'h0, 1'b1, 1'b1, 8'h01));
      repeat (100) @(posedge mclk);
      chk_out("cooled", expo(rc, 1'b0, 1'b1, 8'h0));
      pin(2, 1'b1);
      ack(2);
      chk_out("thm", expo(3'h0, 1'b1, 1'b1, 8'h04));
      pin(2, 1'b0);
      chk_out("thm free", expo(rc, 1'b0, 1'b1, 8'h0));
      $display("test protection kinds done");
      wr(`MFA_A_CTRL, 32'h1);
      pin(1, 1'b1);
      pin(1, 1'b0);
      repeat (110) @(posedge mclk);
      chk_out("auto", expo(rc, 1'b0, 1'b1, 8'h0));
      // Stored mode, so a wrongly enabled automatic reset would release the foreign kind.
      wr(`MFA_A_ACKMODE, 32'hFF);
      pin(6, 1'b1);
      pin(6, 1'b0);
      repeat (30) @(posedge mclk);
      chk_out("no auto", expo(3'h0, 1'b1, 1'b1, 8'h40));
      ack(5);
      chk_out("manual", expo(rc, 1'b0, 1'b1, 8'h0));
      wr(`MFA_A_CTRL, 32'h0);
      $display("test auto reset done");
      wr(`MFA_A_CLASS, 32'hE400);
      pin(5, 1'b1);
      chk_out("warn", expo(rc, 1'b0, 1'b1, 8'h20));
      pin(5, 1'b0);
      pin(6, 1'b1);
      chk_out("off", expo(3'h0, 1'b1, 1'b1, 8'h40));
      pin(6, 1'b0);
      chk_out("off gone", expo(rc, 1'b0, 1'b1, 8'h0));
      pin(7, 1'b1);
      run_cmd <= ~rc;
      chk_out("keep", expo(rc, 1'b1, 1'b1, 8'h80));
      pin(7, 1'b0);
      ack(4);
      chk_out("keep gone", expo(~rc, 1'b0, 1'b1, 8'h0));
      $display("test classes done");
      wr(`MFA_A_ISTAT, 32'hFF);
      wr(`MFA_A_IMASK, 32'h0);
      pin(4, 1'b1);
      chk_irq(1'b0);
      wr(`MFA_A_IMASK, 32'h10);
      chk_irq(1'b1);
      wr(`MFA_A_ISTAT, 32'h10);
      chk_irq(1'b0);
      $display("test interrupt done");
      summarize();
   end
endmodule
`default_nettype wire

/* File: dv/mfa_op_model.sv */
/*
 Operator side model: both test/reset buttons, three auxiliary reset buttons and the motor-off button.
 Assumes go is a one-cycle pulse on mclk and that hold is at least 6, so presses pass the pin filter.
*/
`timescale 1ns/100ps
`default_nettype none
module mfa_op_model (
   input wire logic mclk,
   input wire logic go,
   input wire logic [2:0] sel,
   input wire logic [3:0] hold,
   output logic [5:0] btn
);
   logic [4:0] cnt = 5'h00;
   logic [2:0] cur = 3'h0;
   // A press lasts hold cycles, so slow and quick operators are both covered.
   always_ff @(posedge mclk) begin
      if (go) begin
         cnt <= {1'b0, hold};
         cur <= sel;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
   end
   // Index 0 and 1 are the test/reset buttons, 2 to 4 the auxiliary inputs, 5 motor off.
   // A released button falls back to its pull-down level.
   assign btn = (cnt != 5'h00) ? 6'h01 << cur : 6'h00;
endmodule
`default_nettype wire
